// *** core/isps_filter.sv ***
`timescale 1ns/100ps
// The output follows the input once it has differed for limit cycles.
module isps_filter
    import isps_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Sample and window
    input  wire logic             sample,
    input  wire logic [CNT_W-1:0] limit,
    // Filtered level
    output logic                  level
);

    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cnt_reg <= '0;
            level   <= 1'b0;
        end
        else if (sample == level)
        begin
            cnt_reg <= '0;
        end
        else if (cnt_reg + 1'b1 >= limit)
        begin
            cnt_reg <= '0;
            level   <= sample;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

endmodule

// *** core/isps_pkg.sv ***
// Behaviour
// - Terminals sharing one function are ORed.
// - Speed priority: jog, multi-speed, then PID.
// - Shutoff input covers missing run-enable or interlock.
// - Multi-speed and remote setting share terminals.
// - Special pole counts route method switch via set two.
// - Mode 2: run-enable 2ms, shutoff 20ms.
// - Mode 2 without run-enable: shutoff 2ms, polarity ignored.
// - Shutoff cuts drive output at once.
// - Shutoff blocks start commands.
// - Start removal ramps down; shutoff coasts.
// - Polarity 0 closed asserts; 2 open asserts.
// - Shutoff movable to any terminal by code 24.
// - Shutoff works in every operation mode.
// - Set selects activate second or third set.
// - Third set needs code 9 mapped.
// - Validity 0 switches sets immediately.
// - Validity 10 switches only at constant speed; here the first set is forced whenever speed is not constant.
// - Per-function copies; some lack third copy.
// - Second select movable by code 3.
package isps_pkg;

    localparam int CLK_HZ      = 50_000_000;
    localparam int FAST_MS     = 2;
    localparam int SLOW_MS     = 20;
    localparam int FAST_CYC    = FAST_MS * (CLK_HZ / 1000);
    localparam int SLOW_CYC    = SLOW_MS * (CLK_HZ / 1000);
    localparam int CNT_W       = 20;
    localparam int NUM_TERM    = 12;
    localparam int ADDR_W      = 8;

    localparam logic [7:0] FN_SPEED_LOW  = 8'h00;
    localparam logic [7:0] FN_SPEED_MID  = 8'h01;
    localparam logic [7:0] FN_SPEED_HIGH = 8'h02;
    localparam logic [7:0] FN_SECOND     = 8'h03;
    localparam logic [7:0] FN_JOG        = 8'h05;
    localparam logic [7:0] FN_EXTRA      = 8'h08;
    localparam logic [7:0] FN_THIRD      = 8'h09;
    localparam logic [7:0] FN_RUN_EN     = 8'h0a;
    localparam logic [7:0] FN_INTERLOCK  = 8'h0c;
    localparam logic [7:0] FN_PID        = 8'h0e;
    localparam logic [7:0] FN_BOOST      = 8'h11;
    localparam logic [7:0] FN_CTRL       = 8'h12;
    localparam logic [7:0] FN_SHUTOFF    = 8'h18;
    localparam logic [7:0] FN_NONE       = 8'hff;

    localparam logic [7:0] POL_NO        = 8'h00;
    localparam logic [7:0] POL_NC        = 8'h02;
    localparam logic [7:0] VALID_IMM     = 8'h00;
    localparam logic [7:0] VALID_CONST   = 8'h0a;
    localparam logic [7:0] REGEN_CONV    = 8'h02;
    localparam logic [7:0] OPMODE_LOCK   = 8'h07;
    localparam logic [7:0] REGEN_RST     = 8'h00;
    localparam logic [7:0] OPMODE_RST    = 8'h00;
    localparam logic [7:0] POLES_RST     = 8'h04;

    localparam logic [ADDR_W-1:0] REG_MAP_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_POL      = 8'h30;
    localparam logic [ADDR_W-1:0] REG_VALID    = 8'h34;
    localparam logic [ADDR_W-1:0] REG_REGEN    = 8'h38;
    localparam logic [ADDR_W-1:0] REG_OPMODE   = 8'h3c;
    localparam logic [ADDR_W-1:0] REG_POLES    = 8'h40;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h44;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h48;
    localparam logic [ADDR_W-1:0] REG_TERM     = 8'h4c;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_RUN   = 4'b0010,
        ST_DECEL = 4'b0100,
        ST_COAST = 4'b1000
    } isps_state_t;

    typedef enum logic [1:0] {
        SRC_ANALOG = 2'h0,
        SRC_PID    = 2'h1,
        SRC_MULTI  = 2'h2,
        SRC_JOG    = 2'h3
    } isps_src_t;

    typedef enum logic [1:0] {
        SET_FIRST  = 2'h0,
        SET_SECOND = 2'h1,
        SET_THIRD  = 2'h2
    } isps_set_t;

    typedef struct packed {
        logic [7:0] polarity;
        logic [7:0] validity;
        logic [7:0] regen;
        logic [7:0] op_mode;
        logic [7:0] poles;
        logic       remote_en;
    } isps_cfg_t;

    typedef struct packed {
        logic jog;
        logic low;
        logic mid;
        logic high;
        logic extra;
        logic pid;
        logic second;
        logic third;
        logic run_en;
        logic lock;
        logic boost;
        logic ctrl;
        logic shut_closed;
        logic shut_open;
    } isps_fn_t;

    function automatic logic [7:0] default_code(input int idx);
        logic [7:0] c;
        c = FN_NONE;
        if (idx == 0) c = FN_SPEED_LOW;
        if (idx == 1) c = FN_SPEED_MID;
        if (idx == 2) c = FN_SPEED_HIGH;
        if (idx == 3) c = FN_SECOND;
        if (idx == 4) c = FN_JOG;
        if (idx == 5) c = FN_SHUTOFF;
        return c;
    endfunction

endpackage

// *** core/isps_top.sv ***
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module isps_top
    import isps_pkg::*;
#(
    parameter int NUM_TERMINALS = NUM_TERM,
    parameter int FAST_CYCLES   = FAST_CYC,
    parameter int SLOW_CYCLES   = SLOW_CYC
)
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]        avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    // Contact inputs, high while closed
    input  wire logic [NUM_TERMINALS-1:0] term_in,
    // Drive status
    input  wire logic                     start_cmd,
    input  wire logic                     drive_stopped,
    input  wire logic                     speed_constant,
    // Drive control
    output logic                          gate_enable,
    output logic                          ramp_stop,
    output logic                          coast_stop,
    output logic                          shutoff_active,
    output logic                          converter_ok,
    output logic                          panel_interlock,
    // Speed command
    output isps_src_t                     speed_source,
    output logic      [3:0]               speed_step,
    output logic                          remote_up,
    output logic                          remote_down,
    output logic                          remote_clear,
    // Parameter sets
    output isps_set_t                     param_set,
    output isps_set_t                     param_set_two,
    output logic                          control_method_switch
);

    generate
        if (NUM_TERMINALS < 1 || NUM_TERMINALS > NUM_TERM)
        begin : g_bad_terms
            $error("NUM_TERMINALS out of range");
        end
        if (FAST_CYCLES < 1 || SLOW_CYCLES < 1 || SLOW_CYCLES >= (1 << CNT_W))
        begin : g_bad_cycles
            $error("response cycles out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] FAST_LIM = CNT_W'(FAST_CYCLES);
    localparam logic [CNT_W-1:0] SLOW_LIM = CNT_W'(SLOW_CYCLES);

    logic [7:0]   map_reg [NUM_TERMINALS];
    isps_cfg_t    cfg_reg;
    logic         ack_reg;
    isps_state_t  state_reg;
    isps_state_t  state_next;
    isps_fn_t     act;
    isps_fn_t     asg;
    logic         shut_q;
    logic         run_en_q;
    logic         mode2;
    logic         fast_shut;
    logic         shut_raw;
    logic         run_ok;
    logic         lock_now;
    logic         multi_on;
    logic         special_poles;
    isps_set_t    sel_set;
    isps_set_t    set_next;
    logic [31:0]  rd_next;
    logic         req;
    logic         wr_go;

    // Every function is the OR of all terminals carrying its code.
    function automatic logic [2:0] term_or(input logic [7:0] code);
        logic [2:0] r;
        r = 3'b000;
        for (int i = 0; i < NUM_TERMINALS; i++)
        begin
            if (map_reg[i] == code)
            begin
                r = r | {1'b1, ~term_in[i], term_in[i]};
            end
        end
        return r;
    endfunction

    always_comb
    begin
        logic [2:0] t;
        t = 3'b000;
        act = '0;
        asg = '0;
        t = term_or(FN_JOG);        act.jog    = t[0]; asg.jog    = t[2];
        t = term_or(FN_SPEED_LOW);  act.low    = t[0]; asg.low    = t[2];
        t = term_or(FN_SPEED_MID);  act.mid    = t[0]; asg.mid    = t[2];
        t = term_or(FN_SPEED_HIGH); act.high   = t[0]; asg.high   = t[2];
        t = term_or(FN_EXTRA);      act.extra  = t[0]; asg.extra  = t[2];
        t = term_or(FN_PID);        act.pid    = t[0]; asg.pid    = t[2];
        t = term_or(FN_SECOND);     act.second = t[0]; asg.second = t[2];
        t = term_or(FN_THIRD);      act.third  = t[0]; asg.third  = t[2];
        t = term_or(FN_RUN_EN);     act.run_en = t[0]; asg.run_en = t[2];
        t = term_or(FN_INTERLOCK);  act.lock   = t[0]; asg.lock   = t[2];
        t = term_or(FN_BOOST);      act.boost  = t[0]; asg.boost  = t[2];
        t = term_or(FN_CTRL);       act.ctrl   = t[0]; asg.ctrl   = t[2];
        t = term_or(FN_SHUTOFF);
        act.shut_closed = t[0];
        act.shut_open   = t[1];
        asg.shut_closed = t[2];
        asg.shut_open   = t[2];
    end

    // Shutoff qualification and response window.
    always_comb
    begin
        mode2     = (cfg_reg.regen == REGEN_CONV);
        fast_shut = mode2 && !asg.run_en;
        if (cfg_reg.polarity == POL_NC && !fast_shut)
        begin
            shut_raw = act.shut_open;
        end
        else
        begin
            shut_raw = act.shut_closed;
        end
    end

    isps_filter u_shut_filter (
        .mclk   (mclk),
        .reset  (reset),
        .sample (shut_raw),
        .limit  (fast_shut ? FAST_LIM : SLOW_LIM),
        .level  (shut_q)
    );

    isps_filter u_run_filter (
        .mclk   (mclk),
        .reset  (reset),
        .sample (act.run_en),
        .limit  (FAST_LIM),
        .level  (run_en_q)
    );

    // A missing run-enable or interlock input is served by the shutoff input.
    always_comb
    begin
        if (!mode2)
        begin
            run_ok = 1'b1;
        end
        else if (asg.run_en)
        begin
            run_ok = run_en_q;
        end
        else
        begin
            run_ok = !shut_q;
        end
        lock_now = (cfg_reg.op_mode == OPMODE_LOCK) && (asg.lock ? act.lock : shut_q);
    end

    // The start command may come from panel, terminals or network alike.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (start_cmd && !shut_q && run_ok)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (shut_q || !run_ok)
                begin
                    state_next = ST_COAST;
                end
                else if (!start_cmd)
                begin
                    state_next = ST_DECEL;
                end
            end
            ST_DECEL:
            begin
                if (shut_q || !run_ok)
                begin
                    state_next = ST_COAST;
                end
                else if (start_cmd)
                begin
                    state_next = ST_RUN;
                end
                else if (drive_stopped)
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_COAST:
            begin
                if (drive_stopped && !shut_q)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Gate follows the next state so the cut lands on the edge after shutoff.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            gate_enable     <= 1'b0;
            ramp_stop       <= 1'b0;
            coast_stop      <= 1'b0;
            shutoff_active  <= 1'b0;
            converter_ok    <= 1'b0;
            panel_interlock <= 1'b0;
        end
        else
        begin
            gate_enable     <= (state_next == ST_RUN) || (state_next == ST_DECEL);
            ramp_stop       <= (state_next == ST_DECEL);
            coast_stop      <= (state_next == ST_COAST);
            shutoff_active  <= shut_q;
            converter_ok    <= run_ok;
            panel_interlock <= lock_now;
        end
    end

    // Remote mode reuses the low, middle and high speed terminals.
    assign multi_on = !cfg_reg.remote_en && (act.low || act.mid || act.high || act.extra);

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            speed_source <= SRC_ANALOG;
            speed_step   <= 4'h0;
            remote_up    <= 1'b0;
            remote_down  <= 1'b0;
            remote_clear <= 1'b0;
        end
        else
        begin
            if (act.jog)
            begin
                speed_source <= SRC_JOG;
            end
            else if (multi_on)
            begin
                speed_source <= SRC_MULTI;
            end
            else if (act.pid)
            begin
                speed_source <= SRC_PID;
            end
            else
            begin
                speed_source <= SRC_ANALOG;
            end
            speed_step   <= (multi_on && !act.jog) ? {act.extra, act.high, act.mid, act.low} : 4'h0;
            remote_up    <= cfg_reg.remote_en && act.high;
            remote_down  <= cfg_reg.remote_en && act.mid;
            remote_clear <= cfg_reg.remote_en && act.low;
        end
    end

    // Third wins when both selects are on, since its terminal must be mapped on purpose.
    always_comb
    begin
        if (act.third)
        begin
            sel_set = SET_THIRD;
        end
        else if (act.second)
        begin
            sel_set = SET_SECOND;
        end
        else
        begin
            sel_set = SET_FIRST;
        end
        if (cfg_reg.validity == VALID_CONST && !speed_constant)
        begin
            set_next = SET_FIRST;
        end
        else
        begin
            set_next = sel_set;
        end
        special_poles = (cfg_reg.poles == 8'h0c) || (cfg_reg.poles == 8'h0e) || (cfg_reg.poles == 8'h10)
                     || (cfg_reg.poles == 8'h12) || (cfg_reg.poles == 8'h14);
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            param_set             <= SET_FIRST;
            param_set_two         <= SET_FIRST;
            control_method_switch <= 1'b0;
        end
        else
        begin
            param_set     <= set_next;
            param_set_two <= (set_next == SET_THIRD) ? SET_FIRST : set_next;
            if (asg.ctrl || asg.boost)
            begin
                control_method_switch <= act.ctrl;
            end
            else
            begin
                control_method_switch <= special_poles && (set_next == SET_SECOND);
            end
        end
    end

    // Every access takes one wait state; the answer is at the second edge.
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_reg;
    assign wr_go           = avs_write && ack_reg && avs_byteenable[0];

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= req && !ack_reg;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_TERMINALS; i++)
            begin
                map_reg[i] <= default_code(i);
            end
        end
        else if (wr_go)
        begin
            for (int i = 0; i < NUM_TERMINALS; i++)
            begin
                if (avs_address[ADDR_W-1:2] == 6'(i) + REG_MAP_BASE[ADDR_W-1:2])
                begin
                    map_reg[i] <= avs_writedata[7:0];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cfg_reg.polarity  <= POL_NO;
            cfg_reg.validity  <= VALID_IMM;
            cfg_reg.regen     <= REGEN_RST;
            cfg_reg.op_mode   <= OPMODE_RST;
            cfg_reg.poles     <= POLES_RST;
            cfg_reg.remote_en <= 1'b0;
        end
        else if (wr_go)
        begin
            unique case ({avs_address[ADDR_W-1:2], 2'b00})
                REG_POL:    cfg_reg.polarity  <= avs_writedata[7:0];
                REG_VALID:  cfg_reg.validity  <= avs_writedata[7:0];
                REG_REGEN:  cfg_reg.regen     <= avs_writedata[7:0];
                REG_OPMODE: cfg_reg.op_mode   <= avs_writedata[7:0];
                REG_POLES:  cfg_reg.poles     <= avs_writedata[7:0];
                REG_CTRL:   cfg_reg.remote_en <= avs_writedata[0];
                default:    cfg_reg.remote_en <= cfg_reg.remote_en;
            endcase
        end
    end

    always_comb
    begin
        rd_next = 32'h0;
        for (int i = 0; i < NUM_TERMINALS; i++)
        begin
            if (avs_address[ADDR_W-1:2] == 6'(i) + REG_MAP_BASE[ADDR_W-1:2])
            begin
                rd_next = {24'h0, map_reg[i]};
            end
        end
        unique case ({avs_address[ADDR_W-1:2], 2'b00})
            REG_POL:    rd_next = {24'h0, cfg_reg.polarity};
            REG_VALID:  rd_next = {24'h0, cfg_reg.validity};
            REG_REGEN:  rd_next = {24'h0, cfg_reg.regen};
            REG_OPMODE: rd_next = {24'h0, cfg_reg.op_mode};
            REG_POLES:  rd_next = {24'h0, cfg_reg.poles};
            REG_CTRL:   rd_next = {31'h0, cfg_reg.remote_en};
            REG_STATUS: rd_next = {16'h0, state_reg, param_set, speed_source,
                                   3'h0, control_method_switch, panel_interlock, converter_ok, shutoff_active, gate_enable};
            REG_TERM:   rd_next = 32'(term_in);
            default:    rd_next = rd_next;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            avs_readdata <= 32'h0;
        end
        else if (avs_read && !ack_reg)
        begin
            avs_readdata <= rd_next;
        end
    end

endmodule

// *** dv/isps_contacts.sv ***
`timescale 1ns/100ps
module isps_contacts
    import isps_pkg::*;
(
    // Clock
    input  wire logic                mclk,
    // Requested levels and pace
    input  wire logic [NUM_TERM-1:0] want,
    input  wire logic                slow,
    // Terminal levels
    output logic      [NUM_TERM-1:0] term_in
);
    logic [1:0] age;
    // A slow contact settles a few cycles late, as a relay would.
    always_ff @(posedge mclk)
    begin
        age <= (want != term_in && slow && age != 2'h2) ? age + 2'h1 : 2'h0;
        if (!slow || age == 2'h2)
            term_in <= want;
    end
endmodule

// *** dv/isps_monitor.sv ***
`timescale 1ns/100ps
module isps_monitor
    import isps_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // Bus handshake
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    // Drive control
    input wire logic       gate_enable,
    input wire logic       ramp_stop,
    input wire logic       coast_stop,
    input wire logic       shutoff_active,
    // Commands and sets
    input wire isps_src_t  speed_source,
    input wire logic [3:0] speed_step,
    input wire isps_set_t  param_set,
    input wire isps_set_t  param_set_two
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_wait; (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    property p_coast; $rose(shutoff_active) && $past(gate_enable) |-> coast_stop; endproperty
    a_coast: assert property (p_coast) else $error("shutoff did not coast");
    property p_cut; shutoff_active |-> !gate_enable && !ramp_stop; endproperty
    a_cut: assert property (p_cut) else $error("output on under shutoff");
    property p_hold; coast_stop |-> !ramp_stop && !gate_enable; endproperty
    a_hold: assert property (p_hold) else $error("coast mixed with ramp");
    property p_start; $rose(gate_enable) |-> !shutoff_active; endproperty
    a_start: assert property (p_start) else $error("start taken under shutoff");
    property p_two; param_set == SET_THIRD |-> param_set_two == SET_FIRST; endproperty
    a_two: assert property (p_two) else $error("third copy used");
    property p_pset; param_set != SET_THIRD |-> param_set_two == param_set; endproperty
    a_pset: assert property (p_pset) else $error("set copies differ");
    property p_jog; speed_source != SRC_MULTI |-> speed_step == 4'h0; endproperty
    a_jog: assert property (p_jog) else $error("step outside multi");
endmodule

// *** dv/tb_input_shutoff_and_param_set_select.sv ***
`timescale 1ns/100ps
module tb_input_shutoff_and_param_set_select;
    import isps_pkg::*;
    logic                mclk, reset, avs_read, avs_write, avs_waitrequest, slow;
    logic                start_cmd, drive_stopped, gate_enable, ramp_stop, coast_stop, shutoff_active;
    logic                speed_constant;
    logic [3:0]          speed_step;
    logic [7:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata, q;
    logic [NUM_TERM-1:0] term_in, want;
    isps_src_t           speed_source;
    isps_set_t           param_set, param_set_two;
    int                  miscompares, checked, i;
    isps_top #(.FAST_CYCLES(4), .SLOW_CYCLES(20)) isps_top_inst (.mclk(mclk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .term_in(term_in), .start_cmd(start_cmd), .drive_stopped(drive_stopped), .speed_constant(speed_constant),
        .gate_enable(gate_enable), .ramp_stop(ramp_stop), .coast_stop(coast_stop),
        .shutoff_active(shutoff_active), .converter_ok(), .panel_interlock(), .speed_source(speed_source),
        .speed_step(speed_step), .remote_up(), .remote_down(), .remote_clear(), .param_set(param_set),
        .param_set_two(param_set_two), .control_method_switch());
    isps_contacts isps_contacts_inst (.mclk(mclk), .want(want), .slow(slow), .term_in(term_in));
    always #10 mclk = ~mclk;
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The request stands until waitrequest is seen low at a rising edge; data is taken at that edge.
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            miscompares++;
            stop_test();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask
    task automatic wshut(input logic v);
        for (i = 0; i < 200 && shutoff_active !== v; i++) @(negedge mclk);
        @(posedge mclk);
    endtask
    initial
    begin
        mclk = 0; reset = 1; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
        start_cmd = 0; drive_stopped = 1; slow = 0; want = 0; miscompares = 0; checked = 0; speed_constant = 0;
        repeat (6) @(posedge mclk);
        reset <= 0;
        @(posedge mclk);
        bus(1'b1, REG_POLES, 0); chk(q, 32'h4);
        bus(1'b1, 8'h14, 0); chk(q, 32'h18);
        bus(1'b1, 8'h0c, 0); chk(q, 32'h3);
        bus(1'b1, 8'h80, 0); chk(q, 32'h0);
        $display("test registers done");
        slow <= 1; want[3] <= 1; settle(); chk(param_set, SET_SECOND);
        bus(1'b0, 8'h18, FN_THIRD); want[6] <= 1; settle(); chk(param_set, SET_THIRD);
        chk(param_set_two, SET_FIRST);
        bus(1'b0, 8'h1c, FN_SECOND); want <= 12'h080; settle(); chk(param_set, SET_SECOND);
        want <= 0; settle(); chk(param_set, SET_FIRST);
        bus(1'b0, REG_VALID, VALID_CONST); want <= 12'h008; settle(); chk(param_set, SET_FIRST);
        speed_constant <= 1; settle(); chk(param_set, SET_SECOND);
        $display("test parameter sets done");
        slow <= 0; want <= 12'h011; settle(); chk(speed_source, SRC_JOG); chk(speed_step, 4'h0);
        want <= 12'h001; settle(); chk(speed_source, SRC_MULTI); chk(speed_step, 4'h1);
        want <= 0;
        $display("test speed priority done");
        start_cmd <= 1; drive_stopped <= 0; settle(); chk(gate_enable, 1'b1);
        want[5] <= 1; wshut(1'b1); chk(i >= 20 && i < 30, 1'b1);
        chk(coast_stop, 1'b1);
        chk(gate_enable, 1'b0);
        settle(); chk(gate_enable, 1'b0);
        start_cmd <= 0; drive_stopped <= 1; want[5] <= 0; wshut(1'b0); chk(shutoff_active, 1'b0);
        $display("test shutoff done");
        bus(1'b0, REG_POL, POL_NC); wshut(1'b1); chk(shutoff_active, 1'b1);
        want[5] <= 1; wshut(1'b0); chk(shutoff_active, 1'b0);
        bus(1'b0, REG_REGEN, REGEN_CONV); wshut(1'b1); chk(i < 12, 1'b1);
        want[5] <= 0; wshut(1'b0); chk(shutoff_active, 1'b0);
        $display("test polarity done");
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        stop_test();
    end
endmodule
bind isps_top isps_monitor isps_monitor_inst (.mclk(mclk), .reset(reset), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .gate_enable(gate_enable), .ramp_stop(ramp_stop),
    .coast_stop(coast_stop), .shutoff_active(shutoff_active), .speed_source(speed_source),
    .speed_step(speed_step), .param_set(param_set), .param_set_two(param_set_two));
